// ---- core/trovd_defs.svh ----
/*
  Timing and geometry constants for the triple redundant output voter.
  Assumes a 200 MHz clock; included by the package and design files.
*/
`ifndef TROVD_DEFS_SVH
`define TROVD_DEFS_SVH

// Clock period in picoseconds
`define TROVD_CLK_PS 5000
// Number of output points
`define TROVD_NPTS 32
// Point index width
`define TROVD_PW 5
// DC inversion window, ns; kept short, well inside the hard limit
`define TROVD_DC_GLITCH_NS 500
// DC inversion hard limit, ns
`define TROVD_DC_LIMIT_NS 2000000
// DC glitch in cycles, rounded down
`define TROVD_DC_GLITCH_CYC ((`TROVD_DC_GLITCH_NS * 1000) / `TROVD_CLK_PS)
// Gap between two diagnostic steps, cycles
`define TROVD_GAP_CYC 16'h0100
// Counter width
`define TROVD_CW 16
// Channel count
`define TROVD_NCH 3

`endif

// ---- core/trovd_pkg.sv ----
/*
  Types for the triple redundant output voter with diagnostics.
  Assumes trovd_defs.svh is on the include path.
*/
`include "trovd_defs.svh"

package trovd_pkg;

  // Diagnostic sequencer states
  typedef enum logic [2:0] {
    TROVD_IDLE = 3'h0,
    TROVD_FORCE = 3'h1,
    TROVD_CHECK = 3'h2,
    TROVD_GAP = 3'h3,
    TROVD_HALT = 3'h4
  } trovd_state_t;

  // Field supervision inputs for one point
  typedef struct packed {
    logic volt;      // Voltage seen at the terminal
    logic curr;      // Load current flowing
    logic pwr_ok;    // Field power and fuse good
  } trovd_sense_t;

  // Field fault flags for one point
  typedef struct packed {
    logic pwr_loss;  // Power lost or fuse blown
    logic open_load; // Load open or missing
    logic false_on;  // Load energised in error
    logic short_off; // Load shorted while off
  } trovd_ffault_t;

endpackage

// ---- core/trovd_vote.sv ----
/*
  Two-out-of-three voter of one point over three channel drivers.
  Assumes all inputs are on the same clock domain; combinational.
*/
`timescale 1ns/1ps

module trovd_vote
  import trovd_pkg::*;
(
  input wire logic [2:0] drv,
  input wire logic dual_mode,
  output logic [1:0] sw_on
)
;

  // Majority across the three drivers
  function automatic logic maj(input logic [2:0] d);
    maj = (d[0] & d[1]) | (d[1] & d[2]) | (d[0] & d[2]);
  endfunction

  // Both switches get their own vote in dual mode; single path holds switch two off
  always_comb
  begin
    sw_on[0] = maj(drv);
    sw_on[1] = dual_mode ? maj(drv) : 1'b0;
  end

endmodule

// ---- core/trovd_top.sv ----
/*
  Triple redundant digital output voter with sequential diagnostic,
  relay readback and field supervision.
  Assumes three channel tables from three separate processors, all
  synchronised to clk by the caller; readback and field pins are
  asynchronous and are double flopped here.
*/
// Function
// - Point on only with two of three drivers
// - Each channel fed only by own processor
// - Dual variant votes each switch separately
// - Diagnostic inverts one driver at a time
// - Readback compared with expected after inversion
// - AC inversion at most half mains cycle; code holds it from one rising crossing to the next, a full cycle
// - DC inversion below two milliseconds
// - Diagnostic can be disabled entirely
// - AC variant stops diagnostics after fault
// - AC faulty excursion limited half cycle; code allows a full cycle, rising crossing to rising crossing
// - DC diagnostic covers static commanded points
// - Relay variant drives relays from vote
// - Relay contacts checked via loopback
// - Supervised variant senses voltage and current
// - Supervised variant detects four field faults
// - Supervised variant alarms on missing load
`timescale 1ns/1ps
`include "trovd_defs.svh"

module trovd_top
  import trovd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [`TROVD_NPTS-1:0] tbl_a,
  input wire logic [`TROVD_NPTS-1:0] tbl_b,
  input wire logic [`TROVD_NPTS-1:0] tbl_c,
  input wire logic ac_mode,
  input wire logic dual_mode,
  input wire logic diag_disable,
  input wire logic zero_cross,
  input wire logic [`TROVD_NPTS-1:0] loopback,
  input wire trovd_sense_t [`TROVD_NPTS-1:0] sense,
  output logic [`TROVD_NPTS-1:0] drv_a,
  output logic [`TROVD_NPTS-1:0] drv_b,
  output logic [`TROVD_NPTS-1:0] drv_c,
  output logic [`TROVD_NPTS-1:0] voted,
  output logic [`TROVD_NPTS-1:0] voted_sw2,
  output logic [`TROVD_NPTS-1:0] latent_fault,
  output trovd_ffault_t [`TROVD_NPTS-1:0] field_fault,
  output logic load_alarm,
  output logic diag_halted
);

  // Synchronisers for pins
  logic [`TROVD_NPTS-1:0] lb_s1_r;
  logic [`TROVD_NPTS-1:0] lb_s2_r;
  trovd_sense_t [`TROVD_NPTS-1:0] sn_s1_r;
  trovd_sense_t [`TROVD_NPTS-1:0] sn_s2_r;
  logic [2:0] zc_sh_r; // Bits 0,1 sync, bit 2 edge history
  logic zc_pulse;      // One-cycle zero-crossing event
  logic [1:0] zc_arm_r; // Cycles since reset, saturating at three

  // Diagnostic sequencer state
  trovd_state_t st_r, st_nxt;
  logic [`TROVD_PW-1:0] pt_r, pt_nxt;   // Point under test
  logic [1:0] ch_r, ch_nxt;             // Channel being inverted
  logic [`TROVD_CW-1:0] cnt_r, cnt_nxt; // Window counter
  logic [`TROVD_NPTS-1:0] lf_r, lf_nxt; // Latent fault flags
  logic halt_r, halt_nxt;               // AC stop after fault

  // Field fault and output registers
  trovd_ffault_t [`TROVD_NPTS-1:0] ff_r, ff_nxt;
  logic alarm_r, alarm_nxt;
  logic [`TROVD_NPTS-1:0] da_nxt, db_nxt, dc_nxt;
  // Voter results, switch one and switch two
  logic [`TROVD_NPTS-1:0] vt, vt2;

  // Window length in cycles; floor so the DC limit is never passed
  localparam logic [`TROVD_CW-1:0] DC_WIN =
    `TROVD_CW'(`TROVD_DC_GLITCH_CYC);

  // Window counter step, shared by the inversion and gap states
  function automatic logic [`TROVD_CW-1:0] cnt_dec(
    input logic [`TROVD_CW-1:0] c
  );
    cnt_dec = c - `TROVD_CW'(1);
  endfunction

  // Pin synchronisers, two stages each
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lb_s1_r <= '0;
      lb_s2_r <= '0;
      sn_s1_r <= '0;
      sn_s2_r <= '0;
      zc_sh_r <= 3'h0;
      zc_arm_r <= 2'h0;
    end
    else
    begin
      // Readback of the terminals
      lb_s1_r <= loopback;
      lb_s2_r <= lb_s1_r;
      // Field sense bits
      sn_s1_r <= sense;
      sn_s2_r <= sn_s1_r;
      // Zero-cross pin, two stages and one bit of history
      zc_sh_r <= {zc_sh_r[1], zc_sh_r[0], zero_cross};
      // Count until the history bit holds a real sample
      if (!(&zc_arm_r))
        zc_arm_r <= zc_arm_r + 2'h1;
    end
  end

  // Rising zero crossing from synced and history bits only; held off
  // until both bits carry real samples, so a pin that is high at
  // reset release is not taken for a crossing
  assign zc_pulse = zc_sh_r[1] & ~zc_sh_r[2] & (&zc_arm_r);

  // Per-channel drivers: each table feeds only its own channel
  always_comb
  begin
    da_nxt = tbl_a;
    db_nxt = tbl_b;
    dc_nxt = tbl_c;
    // Inversion stands through the force and check states
    if (st_r == TROVD_FORCE || st_r == TROVD_CHECK)
    begin
      // Invert exactly one driver of one point
      unique case (ch_r)
        2'h0: da_nxt[pt_r] = ~tbl_a[pt_r];
        2'h1: db_nxt[pt_r] = ~tbl_b[pt_r];
        default: dc_nxt[pt_r] = ~tbl_c[pt_r];
      endcase
    end
  end

  // Voters, one per point, on the registered drivers
  genvar gi;
  generate
    for (gi = 0; gi < `TROVD_NPTS; gi++)
    begin : g_vote
      // Switch two is voted only in the dual variant
      trovd_vote u_vote (
        .drv({drv_c[gi], drv_b[gi], drv_a[gi]}),
        .dual_mode(dual_mode),
        .sw_on({vt2[gi], vt[gi]})
      );
    end
  endgenerate

  // Diagnostic sequencer next state
  always_comb
  begin
    st_nxt = st_r;
    pt_nxt = pt_r;
    ch_nxt = ch_r;
    cnt_nxt = cnt_r;
    lf_nxt = lf_r;
    halt_nxt = halt_r;
    unique case (st_r)
      TROVD_IDLE:
      begin
        // Start when enabled; AC waits for a zero crossing
        if (diag_disable)
          st_nxt = TROVD_IDLE;
        // A halted AC sequencer never starts again
        else if (halt_r)
          st_nxt = TROVD_HALT;
        else if (!ac_mode || zc_pulse)
        begin
          // Load the DC window; AC ignores the counter
          st_nxt = TROVD_FORCE;
          cnt_nxt = DC_WIN;
        end
      end
      TROVD_FORCE:
      begin
        // Hold inversion; AC ends at next crossing, DC by count
        if (diag_disable)
          st_nxt = TROVD_IDLE;
        else if (ac_mode ? zc_pulse : (cnt_r == '0))
          st_nxt = TROVD_CHECK;
        // DC counts the window down
        else if (!ac_mode)
          cnt_nxt = cnt_dec(cnt_r);
      end
      TROVD_CHECK:
      begin
        // Loopback must still follow the vote of the true tables
        if (lb_s2_r[pt_r] != voted[pt_r])
        begin
          // Sticky flag; nothing but reset clears it
          lf_nxt[pt_r] = 1'b1;
          if (ac_mode)
            halt_nxt = 1'b1;
        end
        // Always move on; a DC fault only flags the point
        st_nxt = TROVD_GAP;
        cnt_nxt = `TROVD_GAP_CYC;
        // Fixed order: channel A, B, C then next point
        if (ch_r == 2'h2)
        begin
          ch_nxt = 2'h0;
          pt_nxt = pt_r + `TROVD_PW'(1);
        end
        else
          ch_nxt = ch_r + 2'h1;
      end
      TROVD_GAP:
      begin
        // Settling gap then repeat forever
        // Drivers are back on the tables here
        if (cnt_r == '0)
          st_nxt = TROVD_IDLE;
        else
          cnt_nxt = cnt_dec(cnt_r);
      end
      TROVD_HALT:
      begin
        // No further iterations after an AC fault
        st_nxt = TROVD_HALT;
      end
      default:
        st_nxt = TROVD_IDLE;
    endcase
  end

  // Field supervision of voltage and current loopback
  always_comb
  begin
    alarm_nxt = 1'b0;
    for (int i = 0; i < `TROVD_NPTS; i++)
    begin
      // Supply fault needs no load state
      ff_nxt[i].pwr_loss = ~sn_s2_r[i].pwr_ok;
      // Energised with voltage but no current: load missing
      ff_nxt[i].open_load = voted[i] & sn_s2_r[i].volt
        & ~sn_s2_r[i].curr;
      // Off but voltage present: energised in error
      ff_nxt[i].false_on = ~voted[i] & sn_s2_r[i].volt;
      // Off with current flowing: shorted load
      ff_nxt[i].short_off = ~voted[i] & ~sn_s2_r[i].volt
        & sn_s2_r[i].curr;
      if (ff_nxt[i].open_load)
        alarm_nxt = 1'b1;
    end
  end

  // Voted results drive the switches; relays use the same path
  always_comb
  begin
    voted = vt;
    voted_sw2 = vt2;
  end

  // Register all state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= TROVD_IDLE;
      pt_r <= '0;
      ch_r <= 2'h0;
      cnt_r <= '0;
      lf_r <= '0;
      halt_r <= 1'b0;
      ff_r <= '0;
      alarm_r <= 1'b0;
      // Drivers low while in reset
      drv_a <= '0;
      drv_b <= '0;
      drv_c <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      pt_r <= pt_nxt;
      ch_r <= ch_nxt;
      cnt_r <= cnt_nxt;
      lf_r <= lf_nxt;
      halt_r <= halt_nxt;
      ff_r <= ff_nxt;
      alarm_r <= alarm_nxt;
      // Drivers follow the tables, one bit forced when under test
      drv_a <= da_nxt;
      drv_b <= db_nxt;
      drv_c <= dc_nxt;
    end
  end

  // Outputs straight from registers; relay contact readback
  // mismatches are reported through the latent flags as well
  assign latent_fault = lf_r;
  assign field_fault = ff_r;
  assign load_alarm = alarm_r;
  assign diag_halted = halt_r;

endmodule

// ---- tb/trovd_properties.sv ----
/* Port checker for trovd_top.
   Assumes a bind from the bench; one clock, reset active low. */
`timescale 1ns/1ps
module trovd_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [31:0] tbl_a,
  input wire logic [31:0] tbl_b,
  input wire logic [31:0] tbl_c,
  input wire logic ac_mode,
  input wire logic dual_mode,
  input wire logic diag_disable,
  input wire logic [31:0] drv_a,
  input wire logic [31:0] drv_b,
  input wire logic [31:0] drv_c,
  input wire logic [31:0] voted,
  input wire logic [31:0] voted_sw2,
  input wire logic [31:0] latent_fault,
  input wire logic [127:0] field_fault,
  input wire logic load_alarm,
  input wire logic diag_halted
);
  logic [95:0] tq_r; // Tables one edge back
  logic [95:0] inv; // Driver bits off their table
  logic [8:0] run_r; // Cycles of current inversion
  // Tables as the drivers should carry them
  always_ff @(posedge clk) tq_r <= {tbl_a, tbl_b, tbl_c};
  assign inv = {drv_a, drv_b, drv_c} ^ tq_r;
  // Length of the ongoing inversion
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) run_r <= 9'h000;
    else run_r <= (|inv) ? run_r + 9'h001 : 9'h000;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_quiet; diag_disable [*3]; endsequence
  sequence s_halted; diag_halted [*3]; endsequence
  a_vote_major:
    assert property ((drv_a & drv_b | drv_b & drv_c | drv_a & drv_c) == voted)
      else $error("voted is not the majority");
  a_sw2_single:
    assert property (!dual_mode |-> voted_sw2 == 32'h0)
      else $error("second switch active in single mode");
  a_sw2_dual:
    assert property (dual_mode |->
      voted_sw2 == (drv_a & drv_b | drv_b & drv_c | drv_a & drv_c))
      else $error("second switch not voted");
  a_alarm_open:
    assert property (load_alarm == |(field_fault & {32{4'h4}}))
      else $error("alarm does not follow open load");
  a_one_inv:
    assert property ($past(resetn) |-> $onehot0(inv))
      else $error("more than one driver inverted");
  a_vote_masks:
    assert property ($past(resetn) && $past(tbl_a == tbl_b && tbl_b == tbl_c)
      |-> voted == $past(tbl_a)) else $error("inversion reached the load");
  a_dc_glitch:
    assert property (!ac_mode |-> run_r <= 9'h066)
      else $error("inversion too long");
  a_off_quiet:
    assert property (s_quiet |=> inv == 96'h0)
      else $error("inversion while disabled");
  a_halt_freeze:
    assert property (s_halted |-> inv == 96'h0 ##1 diag_halted)
      else $error("diagnostic ran after halt");
  a_latent_keep:
    assert property (1'b1 |=> (latent_fault & $past(latent_fault))
      == $past(latent_fault)) else $error("latent flag dropped");
endmodule

// ---- tb/trovd_proc_model.sv ----
/* Three processor channels feeding the voter, and field readback.
   Assumes the bench changes commands on the falling edge. */
`timescale 1ns/1ps
module trovd_proc_model (
  input wire logic [31:0] cmd_a,
  input wire logic [31:0] cmd_b,
  input wire logic [31:0] cmd_c,
  input wire logic [31:0] voted,
  input wire logic [31:0] flip,
  output logic [31:0] tbl_a,
  output logic [31:0] tbl_b,
  output logic [31:0] tbl_c,
  output logic [31:0] loopback
);
  // Each table from its own processor only
  assign tbl_a = cmd_a;
  assign tbl_b = cmd_b;
  assign tbl_c = cmd_c;
  // Terminal readback; flip marks a broken output path
  assign loopback = voted ^ flip;
endmodule

// ---- tb/tb.sv ----
/* Bench for the triple redundant output voter.
   Assumes the design, package and the two tb modules are compiled. */
`timescale 1ns/1ps
module tb;
  import trovd_pkg::*;
  logic clk, resetn, ac_mode, dual_mode, diag_disable, zero_cross;
  logic [31:0] cmd_a, cmd_b, cmd_c, flip, tbl_a, tbl_b, tbl_c, loopback;
  logic [31:0] drv_a, drv_b, drv_c, voted, voted_sw2, latent_fault, exp;
  logic [95:0] drv_all, acc;
  trovd_sense_t [31:0] sense;
  trovd_ffault_t [31:0] field_fault;
  logic load_alarm, diag_halted;
  int miscompares, n_tests, n;
  // Rows: three tables, then the voted result
  logic [127:0] rows [4] = '{
    {32'hCCCCCCCC, 32'hAAAAAAAA, 32'h99999999, 32'h88888888},
    {32'h33333333, 32'h55555555, 32'h66666666, 32'h77777777},
    {32'hFFFFFFFF, 32'h00000000, 32'h00000000, 32'h00000000},
    {32'h00000000, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF}};
  assign drv_all = {drv_c, drv_b, drv_a};
  trovd_proc_model u_trovd_proc_model (.cmd_a, .cmd_b, .cmd_c, .voted,
    .flip, .tbl_a, .tbl_b, .tbl_c, .loopback);
  trovd_top u_trovd_top (.clk, .resetn, .tbl_a, .tbl_b, .tbl_c, .ac_mode,
    .dual_mode, .diag_disable, .zero_cross, .loopback, .sense, .drv_a,
    .drv_b, .drv_c, .voted, .voted_sw2, .latent_fault, .field_fault,
    .load_alarm, .diag_halted);
  task automatic check(input string what, input logic [127:0] seen, e);
    n_tests++;
    if (seen !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, e, seen);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Wait, bounded, for one driver bit to invert
  task automatic wait_inv(input int k);
    n = 0;
    while (drv_all[k] !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  // Gather every driver bit seen high over a stretch
  task automatic run_quiet(input int len);
    acc = 96'h0;
    repeat (len) @(negedge clk) acc |= drv_all;
  endtask
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // Mains zero crossings; the pin toggles every 100 falling edges of clk
  initial
  begin
    zero_cross = 0;
    forever repeat (100) @(negedge clk) zero_cross = ~zero_cross;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  initial
  begin
    {resetn, ac_mode, dual_mode, diag_disable, flip} = {4'h1, 32'h0};
    {cmd_a, cmd_b, cmd_c} = 96'h0;
    sense = {32{3'b001}};
    repeat (3) @(negedge clk);
    check("reset drv", {drv_all, diag_halted}, 0);
    resetn = 1;
    foreach (rows[i])
    begin
      {cmd_a, cmd_b, cmd_c, exp} = rows[i];
      repeat (2) @(negedge clk);
      check("voted", voted, exp);
      check("drv", drv_all, {cmd_c, cmd_b, cmd_a});
      check("sw2", voted_sw2, 0);
    end
    {cmd_a, cmd_b, cmd_c} = {3{32'h10}};
    sense[3].pwr_ok = 0;
    sense[4] = 3'b101;
    sense[5] = 3'b101;
    sense[6] = 3'b011;
    repeat (6) @(negedge clk);
    check("energised", {field_fault[5].false_on,
      field_fault[6].short_off}, 3);
    check("pwr", field_fault[3].pwr_loss, 1);
    check("open", {field_fault[4].open_load, load_alarm}, 3);
    {cmd_a, cmd_b, cmd_c} = 96'h0;
    sense = {32{3'b001}};
    diag_disable = 0;
    foreach (rows[i])
    begin
      wait_inv(i < 3 ? i * 32 : 1);
      check("step", drv_all, 96'h1 << (i < 3 ? i * 32 : 1));
    end
    n = 0;
    while (drv_all[1] === 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    check("glitch", n, 102);
    flip = 32'h4;
    n = 0;
    while (latent_fault[2] !== 1'b1 && n < 6000)
    begin
      @(negedge clk);
      n++;
    end
    check("latent", {latent_fault, diag_halted}, 64'h8);
    diag_disable = 1;
    repeat (3) @(negedge clk);
    run_quiet(1000);
    check("off", acc, 0);
    {cmd_a, cmd_b, cmd_c} = {3{32'hFFFFFFFF}};
    dual_mode = 1;
    repeat (2) @(negedge clk);
    check("cycled on", {voted, voted_sw2}, 64'hFFFFFFFF_FFFFFFFF);
    {cmd_a, cmd_b, cmd_c} = 96'h0;
    repeat (2) @(negedge clk);
    check("cycled off", {voted, voted_sw2}, 0);
    dual_mode = 0;
    {resetn, ac_mode, flip, diag_disable} = {2'h1, 32'h1, 1'h0};
    repeat (3) @(negedge clk);
    check("reset latent", latent_fault, 0);
    resetn = 1;
    n = 0;
    while (diag_halted !== 1'b1 && n < 6000)
    begin
      @(negedge clk);
      n++;
    end
    check("halt", {latent_fault, diag_halted}, 64'h3);
    repeat (3) @(negedge clk);
    run_quiet(1000);
    check("after halt", acc, 0);
    give_verdict();
  end
endmodule
bind trovd_top trovd_properties u_trovd_properties (.clk, .resetn, .tbl_a,
  .tbl_b, .tbl_c, .ac_mode, .dual_mode, .diag_disable, .drv_a, .drv_b,
  .drv_c, .voted, .voted_sw2, .latent_fault, .field_fault(field_fault),
  .load_alarm, .diag_halted);
